// ### include/rtc_defines.svh
/*
  Constants of the real-time clock block: register offsets, field positions,
  reset values and counts.
  Assumes inclusion by bare name from the package and the testbench.
*/
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// Byte offsets
`define RTC_OFF_CTRL    8'h00
`define RTC_OFF_RELOAD  8'h04
`define RTC_OFF_TIME    8'h08
`define RTC_OFF_ALARM   8'h0C
`define RTC_OFF_CYCLE   8'h10
`define RTC_OFF_STATUS  8'h14
`define RTC_OFF_MASK    8'h18
`define RTC_OFF_DIVVAL  8'h1C
`define RTC_OFF_WAKE    8'h20

// Control bits
`define RTC_CTL_EN      0
`define RTC_CTL_OSCOFF  1
`define RTC_CTL_WAKECFG 2
`define RTC_CTL_TICKSEL 3
`define RTC_CTL_ALMSEL  4
`define RTC_CTL_SRC     5

// Status bits
`define RTC_ST_TICK     0
`define RTC_ST_CYCLE    1
`define RTC_ST_ALARM    2
`define RTC_ST_WAKE     3
`define RTC_NSTAT       4

`define RTC_PRE_DIV     6'h3F
`define RTC_RELOAD_RST  20'h00001
`define RTC_DETECT_EDGES 8'h08
`define RTC_DETECT_WIN  16'hFFFF

`endif

// ### include/rtc_pkg.sv
/*
  Types of the real-time clock block.
  Assumes rtc_defines.svh is on the include path.
*/
package rtc_pkg;
  `include "rtc_defines.svh"

  typedef enum logic [1:0] {RTC_DETECT, RTC_RUN, RTC_PWD} rtc_mode_e;

  typedef struct packed {
    logic       mainOscOn;
    logic       lowPowerOscOn;
    logic       wakeReq;
  } rtc_osc_s;

  typedef struct packed {
    rtc_mode_e  mode;
    logic [5:0] pre;
    logic [19:0] div;
    logic [19:0] reload;
    logic [31:0] timeCnt;
    logic [31:0] alarm;
    logic [15:0] cycleN;
    logic [15:0] cycleCnt;
    logic [15:0] wakeDelay;
    logic [15:0] wakeCnt;
    logic [5:0] ctrl;
    logic [`RTC_NSTAT-1:0] status;
    logic [`RTC_NSTAT-1:0] mask;
    logic       irq;
    logic       tickIrq;
    logic       alarmIrq;
    rtc_osc_s   osc;
    logic [2:0] lpSync;
    logic [15:0] detWin;
    logic [7:0] detEdges;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic       awHave;
    logic       wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
  } rtc_state_s;
endpackage

// ### design/rtc_prescaler_alarm_timer.sv
/*
  Real-time clock: divide-by-64 prescale, 20-bit reload divider, 32-bit time
  counter with alarm, cyclic tick count, sticky interrupt status, wake and
  oscillator control for power-down, AXI4-Lite register slave.
  Assumes the oscillator inputs arrive as sampled levels from outside the
  clock domain and that powerDownReq comes from the system on this clock.
*/
`timescale 1ns/10ps
module rtc_prescaler_alarm_timer import rtc_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        oscTick,
  input  wire logic        low_power_osc_in,
  input  wire logic        powerDownReq,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             tick_irq,
  output logic             alarm_irq,
  output logic             irq,
  output logic             mainOscOn,
  output logic             lowPowerOscOn,
  output logic             wakeReq,
  output logic             lowPowerSelected
);

  rtc_state_s st;
  rtc_state_s next_st;

  // Byte-lane merge, called with all four lanes enabled (4'hF) on the control and reload registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Readback mux
  function automatic logic [31:0] readReg(input rtc_state_s s, input logic [7:0] a,
                                          output logic ok);
    logic [31:0] d;
    d = 32'h00000000;
    ok = 1'b1;
    unique case (a)
      `RTC_OFF_CTRL:   d = {26'h0000000, s.ctrl};
      `RTC_OFF_RELOAD: d = {12'h000, s.reload};
      `RTC_OFF_TIME:   d = s.timeCnt;
      `RTC_OFF_ALARM:  d = s.alarm;
      `RTC_OFF_CYCLE:  d = {s.cycleCnt, s.cycleN};
      `RTC_OFF_STATUS: d = {28'h0000000, s.status};
      `RTC_OFF_MASK:   d = {28'h0000000, s.mask};
      `RTC_OFF_DIVVAL: d = {6'h00, s.div, s.pre};
      `RTC_OFF_WAKE:   d = {s.wakeCnt, s.wakeDelay};
      default:         ok = 1'b0;
    endcase
    return d;
  endfunction

  always_comb begin
    logic        okRd;
    logic        preWrap;
    logic        tick;
    logic        doWrite;
    logic [31:0] rd;
    logic [31:0] wv;
    logic [`RTC_NSTAT-1:0] ev;
    logic        lpEdge;
    okRd = 1'b0;
    rd = 32'h00000000;
    wv = 32'h00000000;
    ev = '0;
    preWrap = 1'b0;
    tick = 1'b0;
    doWrite = 1'b0;
    lpEdge = 1'b0;
    next_st = st;

    // Low-power pin through three flops; a change counts when stages two and three differ
    next_st.lpSync = {st.lpSync[1:0], low_power_osc_in};
    lpEdge = (st.lpSync[2] != st.lpSync[1]);

    // Source detection after reset; counters idle meanwhile
    if (st.mode == RTC_DETECT) begin
      next_st.detWin = st.detWin + 16'h0001;
      if (lpEdge && st.detEdges != `RTC_DETECT_EDGES) begin
        next_st.detEdges = st.detEdges + 8'h01;
      end
      if (st.detEdges == `RTC_DETECT_EDGES) begin
        next_st.ctrl[`RTC_CTL_SRC] = 1'b1;
        next_st.mode = RTC_RUN;
      end else if (st.detWin == `RTC_DETECT_WIN) begin
        next_st.ctrl[`RTC_CTL_SRC] = 1'b0;
        next_st.mode = RTC_RUN;
      end
    end

    // Prescale and divider on the oscillator enable
    preWrap = 1'b0;
    tick = 1'b0;
    if (st.mode != RTC_DETECT && st.ctrl[`RTC_CTL_EN] && oscTick) begin
      next_st.pre = st.pre + 6'h01;
      if (st.pre == `RTC_PRE_DIV) begin
        preWrap = 1'b1;
      end
    end
    if (preWrap) begin
      if (st.div == 20'h00000) begin
        tick = 1'b1;
        next_st.div = st.reload - 20'h00001;
      end else begin
        next_st.div = st.div - 20'h00001;
      end
    end
    // 6 + 20 + 32 = 58-bit chain
    if (tick) begin
      next_st.timeCnt = st.timeCnt + 32'h00000001;
      ev[`RTC_ST_TICK] = 1'b1;
      if (st.cycleN != 16'h0000) begin
        if (st.cycleCnt + 16'h0001 >= st.cycleN) begin
          next_st.cycleCnt = 16'h0000;
          ev[`RTC_ST_CYCLE] = 1'b1;
        end else begin
          next_st.cycleCnt = st.cycleCnt + 16'h0001;
        end
      end
    end
    if (st.mode != RTC_DETECT && st.timeCnt == st.alarm) begin
      ev[`RTC_ST_ALARM] = 1'b1;
    end

    // Power-down entry and programmed wake delay
    if (st.mode == RTC_RUN && powerDownReq) begin
      next_st.mode = RTC_PWD;
      next_st.wakeCnt = st.wakeDelay;
    end else if (st.mode == RTC_PWD) begin
      if (!powerDownReq) begin
        next_st.mode = RTC_RUN;
      end else if (st.ctrl[`RTC_CTL_WAKECFG] && tick) begin
        if (st.wakeCnt == 16'h0000) begin
          ev[`RTC_ST_WAKE] = 1'b1;
          next_st.mode = RTC_RUN;
        end else begin
          next_st.wakeCnt = st.wakeCnt - 16'h0001;
        end
      end
    end

    // Oscillator enables; in power-down main stays on only for an enabled main-sourced block with OSCOFF clear
    next_st.osc.lowPowerOscOn = 1'b1;
    next_st.osc.mainOscOn = 1'b1;
    if (next_st.mode == RTC_PWD) begin
      if (!st.ctrl[`RTC_CTL_EN]) begin
        next_st.osc.mainOscOn = 1'b0;
        next_st.osc.lowPowerOscOn = 1'b0;
      end else if (st.ctrl[`RTC_CTL_SRC]) begin
        next_st.osc.mainOscOn = 1'b0;
        next_st.osc.lowPowerOscOn = !st.ctrl[`RTC_CTL_OSCOFF];
      end else begin
        next_st.osc.mainOscOn = !st.ctrl[`RTC_CTL_OSCOFF];
      end
    end
    next_st.osc.wakeReq = next_st.status[`RTC_ST_WAKE];

    // AXI4-Lite write: address and data in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.wHave = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wready = 1'b0;
    end
    doWrite = st.awHave && st.wHave && !st.bvalid;
    if (doWrite) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'h0;
      unique case (st.awAddr)
        `RTC_OFF_CTRL: begin
          wv = merge({26'h0000000, st.ctrl}, st.wData, 4'hF);
          next_st.ctrl[4:0] = wv[4:0];
        end
        `RTC_OFF_RELOAD: begin
          wv = merge({12'h000, st.reload}, st.wData, 4'hF);
          next_st.reload = wv[19:0];
        end
        `RTC_OFF_TIME:  next_st.timeCnt = st.wData;
        `RTC_OFF_ALARM: next_st.alarm = st.wData;
        `RTC_OFF_CYCLE: next_st.cycleN = st.wData[15:0];
        `RTC_OFF_MASK:  next_st.mask = st.wData[`RTC_NSTAT-1:0];
        `RTC_OFF_WAKE:  next_st.wakeDelay = st.wData[15:0];
        `RTC_OFF_STATUS: ;
        `RTC_OFF_DIVVAL: ;
        default:        next_st.bresp = 2'h2;
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // Sticky status; a new event wins over a write-one clear
    if (doWrite && st.awAddr == `RTC_OFF_STATUS) begin
      next_st.status = st.status & ~st.wData[`RTC_NSTAT-1:0];
    end
    next_st.status = next_st.status | ev;

    // AXI4-Lite read, one cycle after address
    if (s_axi_arvalid && st.arready) begin
      rd = readReg(st, s_axi_araddr, okRd);
      next_st.rdata = rd;
      next_st.rresp = okRd ? 2'h0 : 2'h2;
      next_st.rvalid = 1'b1;
      next_st.arready = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // Routed request lines to the external interrupt selector
    next_st.tickIrq = next_st.status[`RTC_ST_TICK] & st.ctrl[`RTC_CTL_TICKSEL];
    next_st.alarmIrq = next_st.status[`RTC_ST_ALARM] & st.ctrl[`RTC_CTL_ALMSEL];
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // Single state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
      st.mode <= RTC_DETECT;
      st.reload <= `RTC_RELOAD_RST;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.osc <= '{mainOscOn: 1'b1, lowPowerOscOn: 1'b1, wakeReq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign tick_irq = st.tickIrq;
  assign alarm_irq = st.alarmIrq;
  assign irq = st.irq;
  assign mainOscOn = st.osc.mainOscOn;
  assign lowPowerOscOn = st.osc.lowPowerOscOn;
  assign wakeReq = st.osc.wakeReq;
  assign lowPowerSelected = st.ctrl[`RTC_CTL_SRC];

endmodule

// ### tb/rtc_assertions.sv
/* Checker of the RTC ports: slave handshakes, refusals, oscillators.
   Assumes it is bound to the top module by the statement at its foot. */
`timescale 1ns/10ps
module rtc_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        irq,
  input wire logic        mainOscOn,
  input wire logic        powerDownReq,
  input wire logic        lowPowerSelected
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Reset idles the slave; own disable so reset itself is watched
  property p_rst;
    disable iff (1'b0) rst |=> s_axi_awready && !s_axi_bvalid && !irq && mainOscOn;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // Read answer one cycle after the take, then held until accepted
  property p_rdLat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rdLat: assert property (p_rdLat) else $error("read answer late");
  property p_rdHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read answer dropped");
  // Write answer follows the joint take and stands until accepted
  property p_wrLat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wrLat: assert property (p_wrLat) else $error("write answer late");
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write answer dropped");
  // One write at a time: address channel closed once taken
  property p_awBusy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_awBusy: assert property (p_awBusy) else $error("second write taken");
  // Read above the last register (0x20) refused with zero data
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  // Low-power source: main oscillator stops in power-down
  property p_lpOff; (lowPowerSelected && powerDownReq)[*3] |-> !mainOscOn; endproperty
  a_lpOff: assert property (p_lpOff) else $error("main oscillator left on");
endmodule

bind rtc_prescaler_alarm_timer rtc_assertions chk (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .irq, .mainOscOn, .powerDownReq, .lowPowerSelected);

// ### tb/tb_rtc_prescaler_alarm_timer.sv
/* Self-checking bench of the RTC through its register slave and pins.
   Assumes package, defines header and checker are compiled before it. */
`timescale 1ns/10ps
`include "rtc_defines.svh"
module tb_rtc_prescaler_alarm_timer import rtc_pkg::*;;
  logic        clock, rst, oscTick, low_power_osc_in, powerDownReq, rnd;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        tick_irq, alarm_irq, irq, mainOscOn, lowPowerOscOn, wakeReq, lowPowerSelected;
  int          nMismatch, compares, cyc, r, t0, a, i;

  rtc_prescaler_alarm_timer uut (.clock, .rst, .oscTick, .low_power_osc_in, .powerDownReq,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tick_irq,
    .alarm_irq, .irq, .mainOscOn, .lowPowerOscOn, .wakeReq, .lowPowerSelected);

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Cycle count, and random oscillator pulses once enabled
  always @(posedge clock) cyc <= cyc + 1;
  always @(posedge clock) if (rnd) oscTick <= 1'($urandom);

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] ad);
    @(posedge clock);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  // Clear the tick flag, then wait for the next tick to raise it
  task automatic nextTick();
    wr(`RTC_OFF_STATUS, 32'h1);
    while (tick_irq !== 1'b0) @(posedge clock);
    while (tick_irq !== 1'b1) @(posedge clock);
  endtask

  // Reset, then optional slow toggling of the low-power pin
  task automatic doReset(input int edges);
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < edges; i++) begin
      repeat (4) @(posedge clock);
      low_power_osc_in <= ~low_power_osc_in;
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog sized above the 65536-cycle detection window plus tests
  initial begin
    repeat (90000) @(posedge clock);
    nMismatch++;
    close_out();
  end

  initial begin
    {rst, oscTick, low_power_osc_in, powerDownReq, rnd} = 5'h10;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hF};
    {nMismatch, compares, cyc} = 0;
    void'($urandom(32'hE3F7));
    @(posedge clock);
    // Quiet pin: main oscillator chosen after the full window
    doReset(0);
    repeat (65600) @(posedge clock);
    cmp("lowPowerSelected", 0, lowPowerSelected);
    rd(`RTC_OFF_RELOAD);
    cmp("reloadReset", 1, rdat);
    // Power-down with enabled, oscillator-off and disabled settings
    for (int k = 0; k < 3; k++) begin
      wr(`RTC_OFF_CTRL, k == 0 ? 32'h1 : k == 1 ? 32'h3 : 32'h0);
      powerDownReq <= 1'b1;
      repeat (8) @(posedge clock);
      cmp("mainOscOn", k == 0, mainOscOn);
      if (k == 2) cmp("lowPowerOscOn", 0, lowPowerOscOn);
      powerDownReq <= 1'b0;
    end
    // Wake out of power-down after the programmed delay of zero ticks
    oscTick <= 1'b1;
    wr(`RTC_OFF_WAKE, 32'h0);
    wr(`RTC_OFF_CTRL, 32'h5);
    powerDownReq <= 1'b1;
    while (wakeReq !== 1'b1) @(posedge clock);
    powerDownReq <= 1'b0;
    rd(`RTC_OFF_STATUS);
    cmp("wakeFlag", 1, rdat[3]);
    wr(`RTC_OFF_STATUS, 32'h8);
    oscTick <= 1'b0;
    repeat (3) @(posedge clock);
    cmp("wakeReq", 0, wakeReq);
    // Toggling pin selects the low-power source; main stops in power-down
    doReset(20);
    repeat (20) @(posedge clock);
    cmp("lowPowerSelected", 1, lowPowerSelected);
    wr(`RTC_OFF_CTRL, 32'h19);
    powerDownReq <= 1'b1;
    repeat (8) @(posedge clock);
    cmp("mainOscOn", 0, mainOscOn);
    powerDownReq <= 1'b0;
    // Tick period with a pulse every cycle, random reload
    r = 1 + $urandom % 4;
    oscTick <= 1'b1;
    wr(`RTC_OFF_RELOAD, r);
    nextTick();
    nextTick();
    t0 = cyc;
    nextTick();
    cmp("tickPeriod", 64 * r, cyc - t0);
    wr(`RTC_OFF_TIME, 32'hFFFFFFFF);
    nextTick();
    rd(`RTC_OFF_TIME);
    cmp("timeWrap", 0, rdat);
    // Alarm a few ticks ahead, random oscillator pulses meanwhile
    rnd <= 1'b1;
    rd(`RTC_OFF_TIME);
    a = rdat + 2 + $urandom % 2;
    wr(`RTC_OFF_ALARM, a);
    wr(`RTC_OFF_STATUS, 32'h4);
    while (alarm_irq !== 1'b0) @(posedge clock);
    while (alarm_irq !== 1'b1) @(posedge clock);
    rd(`RTC_OFF_TIME);
    cmp("alarmTime", a, rdat);
    // Cyclic flag through the mask, then masked, then cleared
    wr(`RTC_OFF_MASK, 32'h2);
    wr(`RTC_OFF_CYCLE, 32'h2);
    wr(`RTC_OFF_STATUS, 32'hF);
    while (irq !== 1'b1) @(posedge clock);
    rd(`RTC_OFF_STATUS);
    cmp("cycleFlag", 1, rdat[1]);
    wr(`RTC_OFF_MASK, 32'h0);
    repeat (3) @(posedge clock);
    cmp("irqMasked", 0, irq);
    wr(`RTC_OFF_MASK, 32'h2);
    wr(`RTC_OFF_STATUS, 32'h2);
    repeat (3) @(posedge clock);
    cmp("irqCleared", 0, irq);
    // Unmapped place refused on both channels
    rd(8'h24);
    cmp("readResp", 2, resp);
    wr(8'h24, 32'h5A5A5A5A);
    cmp("writeResp", 2, resp);
    close_out();
  end
endmodule
